// ---- lhcd_host_command_decoder.sv ----
`timescale 1ns/1ps
module lhcd_host_command_decoder (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic hostStrobe,
  input wire logic cmdDataSel,
  input wire logic writeReadSel,
  input wire logic [7:0] hostWrData,
  input wire logic [1:0] idPins,
  input wire logic [1:0] makerBits,
  input wire logic nvOkIn,
  input wire logic nvPresentIn,
  input wire logic nvBusyIn,
  input wire logic [6:0] biasTrimOffsetIn,
  output logic [7:0] hostRdData_r,
  output logic hostRdValid_r,
  output logic [7:0] biasTrim_r,
  output logic [1:0] tempSlopeSelect_r,
  output logic [3:0] powerSetting_r,
  output logic [6:0] scrollOffset_r,
  output logic [9:0] panelControl_r,
  output logic [3:0] addressControl_r,
  output logic [6:0] lastScanRow_r,
  output logic [6:0] partialFirstRow_r,
  output logic [6:0] partialLastRow_r,
  output logic [5:0] nvControl_r,
  output logic [7:0] fixedLines_r,
  output logic displayOnFlag_r,
  output logic [6:0] columnPointer_r,
  output logic [6:0] rowPointer_r
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] idMeta_r;
  logic [1:0] idSync_r;
  always_ff @(posedge sys_clk) begin
    idMeta_r <= idPins;
    idSync_r <= idMeta_r;
  end

  // ----------------------------------------------------------------
  // Transfer decode
  // ----------------------------------------------------------------
  logic cmdWr;
  logic cmdRd;
  logic datWr;
  logic datRd;
  assign cmdWr = hostStrobe && !cmdDataSel && !writeReadSel;
  assign cmdRd = hostStrobe && !cmdDataSel && writeReadSel;
  assign datWr = hostStrobe && cmdDataSel && !writeReadSel;
  assign datRd = hostStrobe && cmdDataSel && writeReadSel;

  function automatic logic isPattern(input logic [7:0] v, input logic [7:0] mask,
                                     input logic [7:0] pat);
    isPattern = (v & mask) == pat;
  endfunction

  lhcd_pkg::lhcd_param_t pend_r;
  logic [1:0] winSel_r;
  logic nvEn;
  logic [6:0] returnColumn_r;
  logic [6:0] winBound_r [0:3];
  logic [7:0] nvTimer_r [0:3];
  logic colSet;
  logic [6:0] colSetVal;
  assign nvEn = nvControl_r[lhcd_pkg::NV_ENABLE_BIT];

  // ----------------------------------------------------------------
  // Command register writes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pend_r <= lhcd_pkg::LHCD_P_NONE;
      winSel_r <= 2'h0;
      biasTrim_r <= lhcd_pkg::BIAS_TRIM_RESET;
      tempSlopeSelect_r <= 2'h0;
      powerSetting_r <= {lhcd_pkg::PUMP_CTRL_RESET, lhcd_pkg::PANEL_LOAD_RESET};
      scrollOffset_r <= 7'h00;
      panelControl_r <= {2'h0, lhcd_pkg::COLOR_MODE_RESET, 6'h10};
      addressControl_r <= {1'b0, lhcd_pkg::ADDR_CTRL_RESET};
      lastScanRow_r <= lhcd_pkg::LAST_ROW;
      partialFirstRow_r <= 7'h00;
      partialLastRow_r <= lhcd_pkg::LAST_ROW;
      nvControl_r <= lhcd_pkg::NV_CONTROL_RESET;
      fixedLines_r <= 8'h00;
      displayOnFlag_r <= 1'b0;
      returnColumn_r <= 7'h00;
      winBound_r[0] <= 7'h00;
      winBound_r[1] <= 7'h00;
      winBound_r[2] <= lhcd_pkg::LAST_COLUMN;
      winBound_r[3] <= lhcd_pkg::LAST_ROW;
      for (int i = 0; i < 4; i++) begin
        nvTimer_r[i] <= 8'h00;
      end
    end else if (cmdWr && pend_r != lhcd_pkg::LHCD_P_NONE) begin
      pend_r <= lhcd_pkg::LHCD_P_NONE;
      case (pend_r)
        lhcd_pkg::LHCD_P_BIAS: begin
          biasTrim_r <= hostWrData;
        end
        lhcd_pkg::LHCD_P_NVCTL: begin
          nvControl_r <= hostWrData[5:0];
        end
        lhcd_pkg::LHCD_P_LASTROW: begin
          lastScanRow_r <= hostWrData[6:0];
        end
        lhcd_pkg::LHCD_P_PFIRST: begin
          partialFirstRow_r <= hostWrData[6:0];
        end
        lhcd_pkg::LHCD_P_PLAST: begin
          partialLastRow_r <= hostWrData[6:0];
        end
        lhcd_pkg::LHCD_P_WIN: begin
          if (nvEn) begin
            nvTimer_r[winSel_r] <= hostWrData;
          end else begin
            winBound_r[winSel_r] <= hostWrData[6:0];
          end
        end
        lhcd_pkg::LHCD_P_FIXED: begin
          fixedLines_r <= hostWrData;
        end
        default: begin
        end
      endcase
    end else if (cmdWr) begin
      // column and row nibble loads handled with pointers; others, scroll nibbles included, here.
      if (isPattern(hostWrData, 8'hFC, 8'h24)) begin
        tempSlopeSelect_r <= hostWrData[1:0];
      end else if (isPattern(hostWrData, 8'hFC, 8'h28)) begin
        powerSetting_r[1:0] <= hostWrData[1:0];
      end else if (isPattern(hostWrData, 8'hFC, 8'h2C)) begin
        powerSetting_r[3:2] <= hostWrData[1:0];
      end else if (isPattern(hostWrData, 8'hFC, 8'h30)) begin
        pend_r <= lhcd_pkg::LHCD_P_SKIP;
      end else if (isPattern(hostWrData, 8'hF0, 8'h40)) begin
        scrollOffset_r[3:0] <= hostWrData[3:0];
      end else if (isPattern(hostWrData, 8'hF8, 8'h50)) begin
        scrollOffset_r[6:4] <= hostWrData[2:0];
      end else if (hostWrData == 8'h81) begin
        pend_r <= nvEn ? lhcd_pkg::LHCD_P_SKIP : lhcd_pkg::LHCD_P_BIAS;
      end else if (hostWrData == 8'hB9) begin
        // mask form of the shared register
        pend_r <= nvEn ? lhcd_pkg::LHCD_P_BIAS : lhcd_pkg::LHCD_P_SKIP;
      end else if (isPattern(hostWrData, 8'hFC, 8'h84)) begin
        panelControl_r[9:8] <= hostWrData[1:0];
      end else if (isPattern(hostWrData, 8'hF8, 8'h88)) begin
        addressControl_r[2:0] <= hostWrData[2:0];
      end else if (hostWrData == 8'h90) begin
        pend_r <= lhcd_pkg::LHCD_P_FIXED;
      end else if (isPattern(hostWrData, 8'hF8, 8'hA8)) begin
        displayOnFlag_r <= hostWrData[0];
      end else if (isPattern(hostWrData, 8'hF8, 8'hC0)) begin
        panelControl_r[2:0] <= hostWrData[2:0];
      end else if (isPattern(hostWrData, 8'hFC, 8'hD4)) begin
        panelControl_r[7:6] <= hostWrData[1:0];
      end else if (hostWrData == 8'hEE) begin
        addressControl_r[3] <= 1'b0;
      end else if (hostWrData == 8'hEF) begin
        addressControl_r[3] <= 1'b1;
        returnColumn_r <= columnPointer_r;
      end else if (hostWrData == 8'hF1) begin
        pend_r <= lhcd_pkg::LHCD_P_LASTROW;
      end else if (hostWrData == 8'hF2) begin
        pend_r <= lhcd_pkg::LHCD_P_PFIRST;
      end else if (hostWrData == 8'hF3) begin
        pend_r <= lhcd_pkg::LHCD_P_PLAST;
      end else if (isPattern(hostWrData, 8'hFC, 8'hF4)) begin
        pend_r <= lhcd_pkg::LHCD_P_WIN;
        winSel_r <= hostWrData[1:0];
      end else if (hostWrData == 8'hB8) begin
        pend_r <= lhcd_pkg::LHCD_P_NVCTL;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pixel packing
  // ----------------------------------------------------------------
  logic [1:0] wrPhase_r;
  logic [7:0] wrHold_r;
  logic pixWr;
  logic [12:0] pixData;
  always_comb begin
    pixWr = 1'b0;
    pixData = 13'h0000;
    if (datWr) begin
      if (panelControl_r[7:6] == lhcd_pkg::COLOR_MODE_4K) begin
        // Green gains its low bit by copying its top bit.
        if (wrPhase_r == 2'h1) begin
          pixWr = 1'b1;
          pixData = {wrHold_r[7:4], wrHold_r[3:0], wrHold_r[3], hostWrData[7:4]};
        end else if (wrPhase_r == 2'h2) begin
          pixWr = 1'b1;
          pixData = {wrHold_r[3:0], hostWrData[7:4], hostWrData[7], hostWrData[3:0]};
        end
      end else if (wrPhase_r == 2'h1) begin
        // Dropping each colour's low bit stands in for the dither stage.
        pixWr = 1'b1;
        pixData = {wrHold_r[7:4], wrHold_r[2:0], hostWrData[7:6], hostWrData[4:1]};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset || !cmdDataSel) begin
      wrPhase_r <= 2'h0;
      wrHold_r <= 8'h00;
    end else if (datWr) begin
      wrHold_r <= hostWrData;
      if (panelControl_r[7:6] == lhcd_pkg::COLOR_MODE_4K) begin
        wrPhase_r <= (wrPhase_r == 2'h2) ? 2'h0 : wrPhase_r + 2'h1;
      end else begin
        wrPhase_r <= {1'b0, ~wrPhase_r[0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Pointer stepping
  // ----------------------------------------------------------------
  logic rdPhase_r;
  logic step;
  logic [6:0] colNxt;
  logic [6:0] rowNxt;
  // cursor hold advances only on writes
  assign step = pixWr || (datRd && rdPhase_r && !addressControl_r[3]);
  assign colSet = cmdWr && pend_r == lhcd_pkg::LHCD_P_NONE && hostWrData == 8'hEE;
  assign colSetVal = returnColumn_r;

  always_comb begin
    colNxt = columnPointer_r;
    rowNxt = rowPointer_r;
    if (columnPointer_r != lhcd_pkg::LAST_COLUMN) begin
      colNxt = columnPointer_r + 7'h01;
    // wrap column, step row; halt; no wrap in hold
    end else if (addressControl_r[0] && !addressControl_r[3]) begin
      colNxt = 7'h00;
      if (addressControl_r[2]) begin
        rowNxt = (rowPointer_r == 7'h00) ? lhcd_pkg::LAST_ROW : rowPointer_r - 7'h01;
      end else begin
        rowNxt = (rowPointer_r == lhcd_pkg::LAST_ROW) ? 7'h00 : rowPointer_r + 7'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      columnPointer_r <= 7'h00;
      rowPointer_r <= 7'h00;
    end else if (colSet) begin
      columnPointer_r <= colSetVal;
    end else if (cmdWr && pend_r == lhcd_pkg::LHCD_P_NONE) begin
      if (isPattern(hostWrData, 8'hF0, 8'h00)) begin
        columnPointer_r[3:0] <= hostWrData[3:0];
      end else if (isPattern(hostWrData, 8'hF8, 8'h10)) begin
        columnPointer_r[6:4] <= hostWrData[2:0];
      end else if (isPattern(hostWrData, 8'hF0, 8'h60)) begin
        rowPointer_r[3:0] <= hostWrData[3:0];
      end else if (isPattern(hostWrData, 8'hF8, 8'h70)) begin
        rowPointer_r[6:4] <= hostWrData[2:0];
      end
    end else if (step) begin
      columnPointer_r <= colNxt;
      rowPointer_r <= rowNxt;
    end
  end

  // ----------------------------------------------------------------
  // Display memory and read-back
  // ----------------------------------------------------------------
  logic [12:0] ramRd;
  logic [lhcd_pkg::RAM_ADDR_W-1:0] ramAddr;
  assign ramAddr = lhcd_pkg::RAM_ADDR_W'(rowPointer_r * lhcd_pkg::COLUMNS + columnPointer_r);

  lhcd_pixel_ram uRam (
    .sys_clk(sys_clk),
    .wrEn(pixWr),
    .addr(ramAddr),
    .wrData(pixData),
    .rdData_r(ramRd)
  );

  logic [1:0] statIdx_r;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      hostRdData_r <= 8'h00;
      hostRdValid_r <= 1'b0;
      rdPhase_r <= 1'b0;
      statIdx_r <= 2'h0;
    end else begin
      hostRdValid_r <= cmdRd || datRd;
      if (cmdDataSel) begin
        statIdx_r <= 2'h0;
      end
      if (!cmdDataSel || cmdWr) begin
        rdPhase_r <= 1'b0;
      end
      if (datRd) begin
        hostRdData_r <= rdPhase_r ? {ramRd[4:0], 3'h0} : ramRd[12:5];
        rdPhase_r <= ~rdPhase_r;
      end else if (cmdRd) begin
        statIdx_r <= (statIdx_r == 2'h2) ? 2'h0 : statIdx_r + 2'h1;
        case (statIdx_r)
          // status one
          // The dither stage lives outside this block, so its flag reads as zero.
          2'h0: hostRdData_r <= {1'b0,
                                 panelControl_r[1], panelControl_r[2],
                                 addressControl_r[0], displayOnFlag_r,
                                 nvOkIn, nvPresentIn, nvBusyIn};
          2'h1: hostRdData_r <= {lhcd_pkg::REVISION_CODE, biasTrimOffsetIn};
          default: hostRdData_r <= {lhcd_pkg::PRODUCT_CODE, idSync_r, makerBits};
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_slope;
    @(posedge sys_clk) disable iff (reset)
    (cmdWr && pend_r == lhcd_pkg::LHCD_P_NONE && hostWrData[7:2] == 6'h09)
      |=> tempSlopeSelect_r == $past(hostWrData[1:0]);
  endproperty
  a_slope: assert property (p_slope) else $error("slope not loaded");

  property p_addrctl;
    @(posedge sys_clk) disable iff (reset)
    (cmdWr && pend_r == lhcd_pkg::LHCD_P_NONE && hostWrData[7:3] == 5'h11)
      |=> addressControl_r[2:0] == $past(hostWrData[2:0]);
  endproperty
  a_addrctl: assert property (p_addrctl) else $error("address control not loaded");

  property p_halt;
    @(posedge sys_clk) disable iff (reset)
    (step && !colSet && !cmdWr && columnPointer_r == lhcd_pkg::LAST_COLUMN
      && !addressControl_r[0]) |=> columnPointer_r == lhcd_pkg::LAST_COLUMN;
  endproperty
  a_halt: assert property (p_halt) else $error("column moved without wrap");

  property p_wrap;
    @(posedge sys_clk) disable iff (reset)
    (step && !cmdWr && columnPointer_r == lhcd_pkg::LAST_COLUMN && addressControl_r[0]
      && !addressControl_r[3]) |=> columnPointer_r == 7'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("column did not wrap");

  property p_rowwrap;
    @(posedge sys_clk) disable iff (reset)
    (step && !cmdWr && columnPointer_r == lhcd_pkg::LAST_COLUMN && addressControl_r[0]
      && !addressControl_r[3] && !addressControl_r[2] && rowPointer_r == lhcd_pkg::LAST_ROW)
      |=> rowPointer_r == 7'h00;
  endproperty
  a_rowwrap: assert property (p_rowwrap) else $error("row did not wrap");

  property p_hold;
    @(posedge sys_clk) disable iff (reset)
    (cmdWr && pend_r == lhcd_pkg::LHCD_P_NONE && hostWrData == 8'hEF)
      |=> addressControl_r[3] && returnColumn_r == $past(columnPointer_r);
  endproperty
  a_hold: assert property (p_hold) else $error("cursor hold not entered");

  property p_status3;
    @(posedge sys_clk) disable iff (reset)
    (cmdRd && statIdx_r == 2'h2) |=> hostRdData_r[7:4] == lhcd_pkg::PRODUCT_CODE;
  endproperty
  a_status3: assert property (p_status3) else $error("bad product nibble");

  property p_param;
    @(posedge sys_clk) disable iff (reset)
    (cmdWr && pend_r == lhcd_pkg::LHCD_P_LASTROW)
      |=> lastScanRow_r == $past(hostWrData[6:0]);
  endproperty
  a_param: assert property (p_param) else $error("parameter byte not applied");

  c_pix: cover property (@(posedge sys_clk) pixWr);
  c_stat: cover property (@(posedge sys_clk) cmdRd ##2 cmdRd ##2 cmdRd);
  c_wrap: cover property (@(posedge sys_clk) step && columnPointer_r == lhcd_pkg::LAST_COLUMN);
endmodule // lhcd_host_command_decoder

// ---- lhcd_pkg.sv ----
package lhcd_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam logic [6:0] LAST_COLUMN = 7'h61;
  localparam logic [6:0] LAST_ROW = 7'h43;
  localparam int RAM_DEPTH = 6664;
  localparam int RAM_ADDR_W = 13;
  localparam int COLUMNS = 98;
  localparam int PIXEL_W = 13;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BIAS_TRIM_RESET = 8'h67;
  localparam logic [2:0] ADDR_CTRL_RESET = 3'h1;
  localparam logic [1:0] PANEL_LOAD_RESET = 2'h2;
  localparam logic [1:0] PUMP_CTRL_RESET = 2'h3;
  localparam logic [1:0] COLOR_MODE_RESET = 2'h2;
  localparam logic [1:0] SHADE_MODE_RESET = 2'h3;
  localparam logic [5:0] NV_CONTROL_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int NV_ENABLE_BIT = 3;
  localparam logic [1:0] COLOR_MODE_4K = 2'h1;
  localparam logic [1:0] SHADE_DITHER = 2'h3;

  // Identification values are arbitrary.
  localparam logic [3:0] PRODUCT_CODE = 4'hA;
  localparam logic REVISION_CODE = 1'b0;

  // ----------------------------------------------------------------
  // Parameter-byte targets of two-byte commands
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    LHCD_P_NONE = 4'h0,
    LHCD_P_BIAS = 4'h1,
    LHCD_P_NVCTL = 4'h3,
    LHCD_P_LASTROW = 4'h2,
    LHCD_P_PFIRST = 4'h6,
    LHCD_P_PLAST = 4'h7,
    LHCD_P_WIN = 4'h5,
    LHCD_P_FIXED = 4'h4,
    LHCD_P_SKIP = 4'hC
  } lhcd_param_t;

endpackage

// ---- lhcd_pixel_ram.sv ----
`timescale 1ns/1ps
module lhcd_pixel_ram (
  input wire logic sys_clk,
  input wire logic wrEn,
  input wire logic [lhcd_pkg::RAM_ADDR_W-1:0] addr,
  input wire logic [lhcd_pkg::PIXEL_W-1:0] wrData,
  output logic [lhcd_pkg::PIXEL_W-1:0] rdData_r
);
  logic [lhcd_pkg::PIXEL_W-1:0] mem [0:lhcd_pkg::RAM_DEPTH-1];

  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem[addr] <= wrData;
    end
    rdData_r <= mem[addr];
  end
endmodule // lhcd_pixel_ram

// ---- lhcd_host_model.sv ----
`timescale 1ns/1ps
module lhcd_host_model (
  input wire logic sys_clk,
  output logic hostStrobe,
  output logic cmdDataSel,
  output logic writeReadSel,
  output logic [7:0] hostWrData
);
  initial begin
    hostStrobe = 1'b0;
    cmdDataSel = 1'b0;
    writeReadSel = 1'b0;
    hostWrData = 8'h00;
  end
  task automatic xfer(input logic cd, input logic wr, input logic [7:0] b);
    @(posedge sys_clk);
    hostStrobe <= 1'b1;
    cmdDataSel <= cd;
    writeReadSel <= wr;
    hostWrData <= b;
    @(posedge sys_clk);
    hostStrobe <= 1'b0;
    // A released bus shows the inverse so a stale byte is never mistaken for fresh data.
    hostWrData <= ~b;
  endtask
endmodule // lhcd_host_model

// ---- lhcd_host_command_decoder_test.sv ----
`timescale 1ns/1ps
module lhcd_host_command_decoder_test;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic hostStrobe, cmdDataSel, writeReadSel;
  logic [7:0] hostWrData, hostRdData_r, biasTrim_r, fixedLines_r, rd;
  logic [1:0] idPins = 2'h2;
  logic [1:0] makerBits = 2'h1;
  logic nvOkIn = 1'b1;
  logic nvPresentIn = 1'b0;
  logic nvBusyIn = 1'b1;
  logic [6:0] biasTrimOffsetIn = 7'h2B;
  logic hostRdValid_r, displayOnFlag_r;
  logic [1:0] tempSlopeSelect_r;
  logic [3:0] powerSetting_r, addressControl_r;
  logic [6:0] scrollOffset_r, lastScanRow_r, partialFirstRow_r, partialLastRow_r;
  logic [6:0] columnPointer_r, rowPointer_r;
  logic [9:0] panelControl_r;
  logic [5:0] nvControl_r;
  int err_total = 0;
  int tests_run = 0;
  logic [31:0] rows [20] = '{32'h27000003, 32'h26000002, 32'h2900010D, 32'h2C000101,
    32'h4A00020A, 32'h5300023A, 32'h86000302, 32'h8C000404, 32'h89000401, 32'hF1408540,
    32'hF2058605, 32'hF33C873C, 32'h81A589A5, 32'h01000A01, 32'h15000A51, 32'h63000B03,
    32'h74000B43, 32'h90258C25, 32'hA9000D01, 32'hC2000E02};
  logic [39:0] wraps [3] = '{40'h8961430000, 40'h8D61000043, 40'h8861103090};

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  lhcd_host_model host_u (.sys_clk(sys_clk), .hostStrobe(hostStrobe),
    .cmdDataSel(cmdDataSel), .writeReadSel(writeReadSel), .hostWrData(hostWrData));

  lhcd_host_command_decoder dut_u (.sys_clk(sys_clk), .reset(reset), .hostStrobe(hostStrobe),
    .cmdDataSel(cmdDataSel), .writeReadSel(writeReadSel), .hostWrData(hostWrData),
    .idPins(idPins), .makerBits(makerBits), .nvOkIn(nvOkIn), .nvPresentIn(nvPresentIn),
    .nvBusyIn(nvBusyIn), .biasTrimOffsetIn(biasTrimOffsetIn), .hostRdData_r(hostRdData_r),
    .hostRdValid_r(hostRdValid_r), .biasTrim_r(biasTrim_r),
    .tempSlopeSelect_r(tempSlopeSelect_r), .powerSetting_r(powerSetting_r),
    .scrollOffset_r(scrollOffset_r), .panelControl_r(panelControl_r),
    .addressControl_r(addressControl_r), .lastScanRow_r(lastScanRow_r),
    .partialFirstRow_r(partialFirstRow_r), .partialLastRow_r(partialLastRow_r),
    .nvControl_r(nvControl_r), .fixedLines_r(fixedLines_r),
    .displayOnFlag_r(displayOnFlag_r), .columnPointer_r(columnPointer_r),
    .rowPointer_r(rowPointer_r));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic rd_byte(input logic cd, output logic [7:0] b);
    host_u.xfer(cd, 1'b1, 8'h00);
    #1;
    chk("rdValid", hostRdValid_r, 1'b1);
    b = hostRdData_r;
  endtask

  task automatic set_ptr(input logic [6:0] col, input logic [6:0] row);
    host_u.xfer(1'b0, 1'b0, {4'h0, col[3:0]});
    host_u.xfer(1'b0, 1'b0, {5'h02, col[6:4]});
    host_u.xfer(1'b0, 1'b0, {4'h6, row[3:0]});
    host_u.xfer(1'b0, 1'b0, {5'h0E, row[6:4]});
    // The pixel store is registered, so the new address needs one quiet cycle.
    @(posedge sys_clk);
  endtask

  function automatic logic [7:0] obs(input logic [3:0] s);
    case (s)
      4'h0: obs = {6'h00, tempSlopeSelect_r};
      4'h1: obs = {4'h0, powerSetting_r};
      4'h2: obs = {1'b0, scrollOffset_r};
      4'h3: obs = {6'h00, panelControl_r[9:8]};
      4'h4: obs = {4'h0, addressControl_r};
      4'h5: obs = {1'b0, lastScanRow_r};
      4'h6: obs = {1'b0, partialFirstRow_r};
      4'h7: obs = {1'b0, partialLastRow_r};
      4'h8: obs = {2'h0, nvControl_r};
      4'h9: obs = biasTrim_r;
      4'hA: obs = {1'b0, columnPointer_r};
      4'hB: obs = {1'b0, rowPointer_r};
      4'hC: obs = fixedLines_r;
      4'hD: obs = {7'h00, displayOnFlag_r};
      4'hE: obs = {5'h00, panelControl_r[2:0]};
      default: obs = 8'h00;
    endcase
  endfunction

  initial begin
    #(4000 * 25);
    err_total++;
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      host_u.xfer(1'b0, 1'b0, rows[i][31:24]);
      if (rows[i][15]) begin
        host_u.xfer(1'b0, 1'b0, rows[i][23:16]);
      end
      #1;
      chk("cmdRow", obs(rows[i][11:8]), rows[i][7:0]);
    end
    rd_byte(1'b0, rd);
    chk("status1", rd, 8'h5D);
    rd_byte(1'b0, rd);
    chk("status2", rd, 8'h2B);
    rd_byte(1'b0, rd);
    chk("status3", rd, {lhcd_pkg::PRODUCT_CODE, 4'h9});
    set_ptr(7'h00, 7'h00);
    host_u.xfer(1'b1, 1'b0, 8'hB6);
    host_u.xfer(1'b1, 1'b0, 8'h6D);
    #1;
    chk("colAfterPixel", columnPointer_r, 7'h01);
    set_ptr(7'h00, 7'h00);
    rd_byte(1'b1, rd);
    chk("pixelHigh", rd, 8'hBC);
    rd_byte(1'b1, rd);
    chk("pixelLow", rd, 8'hB0);
    foreach (wraps[i]) begin
      host_u.xfer(1'b0, 1'b0, wraps[i][39:32]);
      set_ptr(wraps[i][30:24], wraps[i][22:16]);
      host_u.xfer(1'b1, 1'b0, 8'h12);
      host_u.xfer(1'b1, 1'b0, 8'h34);
      #1;
      chk("wrapPtrs", {columnPointer_r, rowPointer_r}, wraps[i][14:0]);
    end
    host_u.xfer(1'b0, 1'b0, 8'h89);
    set_ptr(7'h05, 7'h02);
    host_u.xfer(1'b0, 1'b0, 8'hEF);
    host_u.xfer(1'b1, 1'b0, 8'h55);
    host_u.xfer(1'b1, 1'b0, 8'hAA);
    rd_byte(1'b1, rd);
    rd_byte(1'b1, rd);
    chk("holdCol", {addressControl_r, columnPointer_r}, {4'h9, 7'h06});
    host_u.xfer(1'b0, 1'b0, 8'hEE);
    #1;
    chk("restoreCol", {addressControl_r, columnPointer_r}, {4'h1, 7'h05});
    host_u.xfer(1'b0, 1'b0, 8'hB8);
    host_u.xfer(1'b0, 1'b0, 8'h08);
    host_u.xfer(1'b0, 1'b0, 8'h81);
    host_u.xfer(1'b0, 1'b0, 8'h11);
    host_u.xfer(1'b0, 1'b0, 8'hF4);
    host_u.xfer(1'b0, 1'b0, 8'h63);
    #1;
    chk("biasRefused", {nvControl_r, biasTrim_r, rowPointer_r}, {6'h08, 8'hA5, 7'h02});
    host_u.xfer(1'b0, 1'b0, 8'hB9);
    host_u.xfer(1'b0, 1'b0, 8'h22);
    host_u.xfer(1'b0, 1'b0, 8'hB8);
    host_u.xfer(1'b0, 1'b0, 8'h00);
    host_u.xfer(1'b0, 1'b0, 8'hF4);
    host_u.xfer(1'b0, 1'b0, 8'h61);
    #1;
    chk("sharedMask", {biasTrim_r, columnPointer_r, rowPointer_r}, {8'h22, 7'h05, 7'h02});
    // Four-bit colour mode: three bytes make two pixels, green extended by its top bit.
    host_u.xfer(1'b0, 1'b0, 8'hD5);
    set_ptr(7'h00, 7'h00);
    host_u.xfer(1'b1, 1'b0, 8'h1A);
    host_u.xfer(1'b1, 1'b0, 8'h34);
    host_u.xfer(1'b1, 1'b0, 8'h56);
    #1;
    chk("col4k", columnPointer_r, 7'h02);
    set_ptr(7'h00, 7'h00);
    rd_byte(1'b1, rd);
    chk("pixel4kHigh", rd, 8'h1A);
    rd_byte(1'b1, rd);
    chk("pixel4kLow", rd, 8'h98);
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("resetCfg", {biasTrim_r, powerSetting_r, panelControl_r, addressControl_r,
      lastScanRow_r, partialFirstRow_r}, {8'h67, 4'hE, 10'h090, 4'h1, 7'h43,
      7'h00});
    chk("resetRest", {partialLastRow_r, nvControl_r, columnPointer_r, rowPointer_r,
      hostRdValid_r, displayOnFlag_r, fixedLines_r, scrollOffset_r, tempSlopeSelect_r},
      {7'h43, 6'h00, 7'h00, 7'h00, 1'b0, 1'b0, 8'h00, 7'h00, 2'h0});
    tally_and_finish();
  end
endmodule // lhcd_host_command_decoder_test
